// ---- rtl/cluster_regs.svh ----
// Register offsets, field positions and sizes of the logic cluster
`ifndef CLUSTER_REGS_SVH
`define CLUSTER_REGS_SVH
`define NUM_CELLS 10
`define RAM_DEPTH 32
`define RAM_WIDTH 20
`define RAM_BITS 640
`define RAM_HALF 10
`define ADDR_W 9
`define CELL_SUB_CTRL 3'h4
`define ADDR_GLOBAL 9'h140
`define ADDR_STATUS_LO 9'h144
`define ADDR_STATUS_HI 9'h148
`define F_MODE 0
`define F_FEEDBACK 2
`define F_DIRECT 3
`define F_BYPASS 4
`define F_PACKED 8
`define F_HONOUR 12
`define F_PRESET 16
`define F_CLRSEL 20
`define F_CLKSEL 28
`define G_SRC0 0
`define G_SRC1 3
`define G_CLKCFG 6
`define G_DEV_EN 12
`define G_RAM_MODE 13
`define G_RAM_WIDTH 15
`define G_BITS 17
`define CTRL_RESET 32'h0000_0000
`define GLOBAL_RESET 17'h0_0000
`define MASK_8 10'h0FF
`define MASK_9 10'h1FF
`define MASK_10 10'h3FF
`endif

// ---- rtl/cluster_pkg.sv ----
// Types shared by the logic cluster design
package cluster_pkg;
`include "cluster_regs.svh"
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_EXTENDED = 2'b01,
    MODE_ARITH = 2'b10,
    MODE_SHARED_ARITH = 2'b11
  } cell_mode_t;
  typedef enum logic [1:0] {
    RAM_OFF = 2'b00,
    RAM_32X20 = 2'b01,
    RAM_64DEEP = 2'b10
  } ram_mode_t;
  typedef struct packed {
    logic [`NUM_CELLS-1:0][3:0][31:0] mask;
    logic [`NUM_CELLS-1:0][31:0] ctrl;
    logic [`G_BITS-1:0] glob;
    logic [`RAM_DEPTH-1:0][`RAM_WIDTH-1:0] mem;
    logic [`NUM_CELLS-1:0][3:0] q;
    logic [5:0] row_s1;
    logic [5:0] row_s2;
    logic [5:0] row_prev;
    logic [1:0] clr_s1;
    logic [1:0] clr_s2;
    logic dev_s1;
    logic dev_s2;
    logic [39:0] cell_out;
    logic [19:0] left;
    logic [19:0] right;
    logic [19:0] ram_rd;
    logic [31:0] rdata;
  } state_t;
endpackage

// ---- rtl/logic_cluster.sv ----
// Ten-cell programmable logic cluster with register file and cluster RAM
// How it works
// RL1: Memory-capable cluster holds at most 640 bits of dual-port RAM.
// RL2: Each cell stores 32x2; ten cells make a 32x20 dual-port RAM.
// RL3: 64-deep arrangements with 8, 9 or 10 bit data are supported.
// RL4: Cluster drives 40 cell outputs; two groups of 20 go to neighbours.
// RL5: Up to three cluster clocks from two sources, each paired with enable.
// RL6: An inverted clock source counts as a separate source.
// RL7: Deasserted enable stops that clock; its registers hold.
// RL8: Cluster controls come from six row clock lines and local inputs.
// RL9: Up to two cluster clears act asynchronously on cell registers.
// RL10: Preset emulated by inverting data in and out; clear gives one.
// RL11: Enabled device-wide clear zeroes every register, above all controls.
// RL12: Four registers per cell with data, clock, clears and load.
// RL13: Two lookup halves share eight inputs; any six-input function fits.
// RL14: Combinational use bypasses registers straight to the outputs.
// RL15: One output may show the lookup result while a register shows another.
// RL16: A register output may feed back into its own cell's lookup.
// RL17: Each cell runs in one of four modes.
// RL18: Two five-input functions share the first two inputs.
// RL19: Two six-input functions need four shared inputs and one function.
// RL20: Six-input function on the first high pair drives registers 0 and 1.
// RL21: Six-input function on the alternate pair drives registers 2 and 3.
// RL22: Neighbours may drive this cluster's inputs over direct links.
// RL23: Sync clear beats sync load, both on enabled edges; async clear at once.
// RL24: Sync clear and load are cluster-wide; each register may ignore them.
`include "cluster_regs.svh"
module logic_cluster (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Cluster control sources
  input wire logic [5:0] row_clock,
  input wire logic [2:0] clk_enable,
  input wire logic [1:0] cluster_clear,
  input wire logic device_wide_clear_n,
  input wire logic sync_clear,
  input wire logic sync_load,
  // Cell data inputs, one bit per cell
  input wire logic [`NUM_CELLS-1:0] cell_input_a,
  input wire logic [`NUM_CELLS-1:0] cell_input_b,
  input wire logic [`NUM_CELLS-1:0] cell_input_c,
  input wire logic [`NUM_CELLS-1:0] cell_input_d,
  input wire logic [`NUM_CELLS-1:0] cell_input_e_low,
  input wire logic [`NUM_CELLS-1:0] cell_input_e_high,
  input wire logic [`NUM_CELLS-1:0] cell_input_f_low,
  input wire logic [`NUM_CELLS-1:0] cell_input_f_high,
  // Direct links from neighbours
  input wire logic [19:0] direct_in_left,
  input wire logic [19:0] direct_in_right,
  // Cluster RAM ports
  input wire logic ram_wr_en,
  input wire logic [5:0] ram_wr_addr,
  input wire logic [`RAM_WIDTH-1:0] ram_wr_data,
  input wire logic [5:0] ram_rd_addr,
  output logic [`RAM_WIDTH-1:0] ram_rd_data,
  // Cell outputs
  output logic [39:0] cell_out,
  output logic [19:0] direct_out_left,
  output logic [19:0] direct_out_right
);

  cluster_pkg::state_t s;
  cluster_pkg::state_t n;
  logic [2:0] tick;
  logic dev_hit;
  logic [`NUM_CELLS-1:0][1:0] res;
  logic [`NUM_CELLS-1:0][3:0] vis;

  function automatic logic row_pick(input logic [5:0] lines, input logic [2:0] sel);
    row_pick = (sel < 3'h6) ? lines[sel] : 1'b0;
  endfunction

  function automatic logic lut_pick(input logic [63:0] mask, input logic [5:0] idx);
    lut_pick = mask[idx];
  endfunction

  function automatic logic [9:0] width_mask(input logic [1:0] sel);
    case (sel)
      2'h0: width_mask = `MASK_8;
      2'h1: width_mask = `MASK_9;
      default: width_mask = `MASK_10;
    endcase
  endfunction

  always_comb begin
    logic [31:0] ctrl;
    logic [1:0] cfg;
    logic [2:0] src;
    logic a;
    logic b;
    logic c;
    logic d;
    logic c0;
    logic c1;
    logic h0;
    logic h1;
    logic [3:0] pk;
    logic [1:0] csel;
    logic [1:0] ksel;
    logic aclr;
    logic t;
    logic pre;
    logic din;
    logic [3:0] sub;
    logic [`RAM_WIDTH-1:0] word;
    logic [9:0] wm;
    ctrl = `CTRL_RESET;
    cfg = 2'h0;
    src = 3'h0;
    a = 1'b0;
    b = 1'b0;
    c = 1'b0;
    d = 1'b0;
    c0 = 1'b0;
    c1 = 1'b0;
    h0 = 1'b0;
    h1 = 1'b0;
    pk = 4'h0;
    csel = 2'h0;
    ksel = 2'h0;
    aclr = 1'b0;
    t = 1'b0;
    pre = 1'b0;
    din = 1'b0;
    sub = 4'h0;
    word = '0;
    wm = `MASK_10;
    n = s;
    res = '0;
    vis = '0;
    tick = 3'h0;
    // Row lines and clears come from other domains
    n.row_s1 = row_clock; // see RL8
    n.row_s2 = s.row_s1;
    n.row_prev = s.row_s2;
    n.clr_s1 = cluster_clear;
    n.clr_s2 = s.clr_s1;
    n.dev_s1 = device_wide_clear_n;
    n.dev_s2 = s.dev_s1;
    // Each cluster clock: source choice, polarity and its own enable
    for (int k = 0; k < 3; k++) begin
      cfg = s.glob[`G_CLKCFG + 2*k +: 2];
      src = cfg[0] ? s.glob[`G_SRC1 +: 3] : s.glob[`G_SRC0 +: 3]; // see RL5
      // Inverted source ticks on the falling transition
      if (cfg[1]) begin
        t = row_pick(s.row_prev, src) & ~row_pick(s.row_s2, src); // see RL6
      end else begin
        t = row_pick(s.row_s2, src) & ~row_pick(s.row_prev, src);
      end
      tick[k] = t & clk_enable[k]; // see RL7
    end
    dev_hit = s.glob[`G_DEV_EN] & ~s.dev_s2;
    for (int i = 0; i < `NUM_CELLS; i++) begin
      ctrl = s.ctrl[i];
      // Direct links replace inputs a..d when chosen
      if (ctrl[`F_DIRECT]) begin
        a = direct_in_left[2*i]; // see RL22
        b = direct_in_left[2*i+1];
        c = direct_in_right[2*i];
        d = direct_in_right[2*i+1];
      end else begin
        a = cell_input_a[i];
        b = cell_input_b[i];
        c = cell_input_c[i];
        d = cell_input_d[i];
      end
      for (int r = 0; r < 4; r++) begin
        vis[i][r] = s.q[i][r] ^ ctrl[`F_PRESET + r]; // see RL10
      end
      c0 = ctrl[`F_FEEDBACK] ? vis[i][0] : c; // see RL16
      c1 = ctrl[`F_FEEDBACK] ? vis[i][2] : c;
      // Halves share a, b, d and, without feedback, c; each adds one e and one f input
      h0 = lut_pick({s.mask[i][1], s.mask[i][0]},
        {cell_input_f_high[i], cell_input_e_low[i], d, c0, b, a}); // see RL13, RL18, RL20
      h1 = lut_pick({s.mask[i][3], s.mask[i][2]},
        {cell_input_f_low[i], cell_input_e_high[i], d, c1, b, a}); // see RL19, RL21
      // Arithmetic modes fall back to normal lookup behaviour
      case (cluster_pkg::cell_mode_t'(ctrl[`F_MODE +: 2]))
        cluster_pkg::MODE_EXTENDED: begin
          res[i][0] = cell_input_f_low[i] ? h1 : h0; // see RL17
          res[i][1] = res[i][0];
        end
        default: begin
          res[i][0] = h0;
          res[i][1] = h1;
        end
      endcase
      // Packed input is an e or f input of the register's own half
      pk = {cell_input_f_low[i], cell_input_e_high[i], cell_input_f_high[i],
        cell_input_e_low[i]};
      ksel = ctrl[`F_CLKSEL +: 2];
      t = (ksel == 2'h3) ? 1'b0 : tick[ksel];
      for (int r = 0; r < 4; r++) begin
        pre = ctrl[`F_PRESET + r];
        csel = ctrl[`F_CLRSEL + 2*r +: 2];
        aclr = ((csel == 2'h1) & s.clr_s2[0]) | ((csel == 2'h2) & s.clr_s2[1]);
        din = ctrl[`F_PACKED + r] ? pk[r] : res[i][r/2];
        if (dev_hit) begin
          n.q[i][r] = 1'b0; // see RL11
        end else if (aclr) begin
          n.q[i][r] = 1'b0; // see RL9, RL23
        end else if (t) begin
          if (ctrl[`F_HONOUR + r] & sync_clear) begin
            n.q[i][r] = 1'b0; // see RL23, RL24
          end else if (ctrl[`F_HONOUR + r] & sync_load) begin
            n.q[i][r] = c ^ pre;
          end else begin
            n.q[i][r] = din ^ pre; // see RL12
          end
        end
        // Bypass shows the lookup result, else the register
        n.cell_out[4*i + r] = ctrl[`F_BYPASS + r] ? res[i][r/2] : vis[i][r]; // see RL14, RL15
      end
    end
    n.left = n.cell_out[19:0]; // see RL4
    n.right = n.cell_out[39:20];
    // Cluster RAM: 32x20 or 64 words of 8..10 bits in the same 640 bits
    wm = width_mask(s.glob[`G_RAM_WIDTH +: 2]);
    case (cluster_pkg::ram_mode_t'(s.glob[`G_RAM_MODE +: 2]))
      cluster_pkg::RAM_32X20: begin
        if (ram_wr_en) begin
          n.mem[ram_wr_addr[4:0]] = ram_wr_data; // see RL1, RL2
        end
        n.ram_rd = s.mem[ram_rd_addr[4:0]];
      end
      cluster_pkg::RAM_64DEEP: begin
        if (ram_wr_en && ram_wr_addr[5]) begin
          n.mem[ram_wr_addr[4:0]][19:10] = ram_wr_data[9:0] & wm; // see RL3
        end else if (ram_wr_en) begin
          n.mem[ram_wr_addr[4:0]][9:0] = ram_wr_data[9:0] & wm;
        end
        word = s.mem[ram_rd_addr[4:0]];
        n.ram_rd = {10'h000, (ram_rd_addr[5] ? word[19:10] : word[9:0]) & wm};
      end
      default: n.ram_rd = '0;
    endcase
    // Register port; reads answer in the next cycle only
    sub = {1'b0, reg_addr[4:2]};
    if (reg_write) begin
      if (reg_addr < `ADDR_GLOBAL && sub < 4'h4) begin
        n.mask[reg_addr[8:5]][sub[1:0]] = reg_wdata;
      end else if (reg_addr < `ADDR_GLOBAL && sub[2:0] == `CELL_SUB_CTRL) begin
        n.ctrl[reg_addr[8:5]] = reg_wdata;
      end else if (reg_addr == `ADDR_GLOBAL) begin
        n.glob = reg_wdata[`G_BITS-1:0];
      end
    end
    n.rdata = 32'h0000_0000;
    if (reg_read) begin
      if (reg_addr < `ADDR_GLOBAL && sub < 4'h4) begin
        n.rdata = s.mask[reg_addr[8:5]][sub[1:0]];
      end else if (reg_addr < `ADDR_GLOBAL && sub[2:0] == `CELL_SUB_CTRL) begin
        n.rdata = s.ctrl[reg_addr[8:5]];
      end else if (reg_addr == `ADDR_GLOBAL) begin
        n.rdata = {15'h0000, s.glob};
      end else if (reg_addr == `ADDR_STATUS_LO) begin
        n.rdata = vis[7:0];
      end else if (reg_addr == `ADDR_STATUS_HI) begin
        n.rdata = {24'h00_0000, vis[9:8]};
      end
    end
  end

  // Unused cell slots (addresses 0x140 and up) never reach the cell arrays
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign ram_rd_data = s.ram_rd;
  assign cell_out = s.cell_out;
  assign direct_out_left = s.left;
  assign direct_out_right = s.right;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_dev_clear_all: assert property (dev_hit |=> s.q == '0) // see RL11
    else $error("device-wide clear left a register set");
  a_async_clear: assert property (!dev_hit && s.clr_s2[0] &&
      s.ctrl[0][`F_CLRSEL +: 2] == 2'h1 |=> s.q[0][0] == 1'b0) // see RL9
    else $error("cluster clear 0 did not clear cell 0 register 0");
  a_hold_no_tick: assert property (!dev_hit && s.clr_s2 == 2'h0 &&
      s.ctrl[0][`F_CLKSEL +: 2] == 2'h0 && !tick[0] |=> $stable(s.q[0])) // see RL7
    else $error("register changed without its clock");
  a_direct_split: assert property (##1 direct_out_left == cell_out[19:0] &&
      direct_out_right == cell_out[39:20]) // see RL4
    else $error("direct-link groups differ from cell outputs");
  a_bypass_path: assert property (s.ctrl[0][`F_BYPASS] |=> cell_out[0] == $past(res[0][0])) // see RL14
    else $error("bypassed output is not the lookup result");
  a_sclr_over_load: assert property (!dev_hit && s.clr_s2 == 2'h0 && tick[0] &&
      s.ctrl[0][`F_CLKSEL +: 2] == 2'h0 && s.ctrl[0][`F_HONOUR] &&
      !s.ctrl[0][`F_PRESET] && sync_clear && sync_load |=> !s.q[0][0]) // see RL23
    else $error("sync load won over sync clear");
  a_ram_readback: assert property (s.glob[`G_RAM_MODE +: 2] == 2'h1 && ram_wr_en ##1 // see RL2
      (ram_rd_addr[4:0] == $past(ram_wr_addr[4:0]) && !ram_wr_en &&
      s.glob[`G_RAM_MODE +: 2] == 2'h1) |=> ram_rd_data == $past(ram_wr_data, 2))
    else $error("RAM read did not return written word");
  a_packed_input: assert property (!dev_hit && s.clr_s2 == 2'h0 && tick[0] &&
      s.ctrl[0][`F_CLKSEL +: 2] == 2'h0 && s.ctrl[0][`F_PACKED + 2] &&
      !s.ctrl[0][`F_HONOUR + 2] && !s.ctrl[0][`F_PRESET + 2]
      |=> s.q[0][2] == $past(cell_input_e_high[0])) // see RL21
    else $error("packed input not captured");
  a_preset_clear: assert property (!dev_hit && s.clr_s2[1] && s.ctrl[0][`F_PRESET] &&
      s.ctrl[0][`F_CLRSEL +: 2] == 2'h2 |=> vis[0][0]) // see RL10
    else $error("emulated preset did not read as one");

  c_ram_write: cover property (ram_wr_en && s.glob[`G_RAM_MODE +: 2] == 2'h2);
  c_dev_clear: cover property (dev_hit ##1 !dev_hit);
  c_tick_all: cover property (tick == 3'h7);
  c_reg_read: cover property (reg_read && reg_addr == `ADDR_STATUS_LO);
  c_inverted_tick: cover property (tick[1] && s.glob[`G_CLKCFG + 3]);

endmodule

// ---- bench/cluster_neighbour.sv ----
// Neighbouring clusters and row clock routing around the cluster
module cluster_neighbour (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Requests from the bench
  input wire logic tick_req,
  input wire logic [2:0] tick_line,
  input wire logic [19:0] pat_left,
  input wire logic [19:0] pat_right,
  // Towards the cluster
  output logic [5:0] row_clock,
  output logic [19:0] direct_in_left,
  output logic [19:0] direct_in_right
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_cnt;
  // Line held high long enough for the two-stage synchroniser
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hold_cnt <= 3'h0;
      row_clock <= 6'h00;
    end else if (tick_req) begin
      hold_cnt <= 3'h4;
      row_clock <= 6'h01 << tick_line;
    end else if (hold_cnt != 3'h0) begin
      hold_cnt <= hold_cnt - 3'h1;
    end else begin
      row_clock <= 6'h00;
    end
  end
  // Neighbours send from their own registers, one cycle behind
  always_ff @(posedge clock) begin
    direct_in_left <= pat_left;
    direct_in_right <= pat_right;
  end
endmodule

// ---- bench/tb_logic_cluster.sv ----
// Self-checking testbench of the logic cluster
`include "cluster_regs.svh"
module tb_logic_cluster;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, reg_write, reg_read, device_wide_clear_n, sync_clear, sync_load;
  logic ram_wr_en, tick_req;
  logic [8:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, seed;
  logic [5:0] row_clock, ram_wr_addr, ram_rd_addr;
  logic [2:0] clk_enable, tline;
  logic [1:0] cluster_clear;
  logic [9:0] a, b, c, d, el, eh, fl, fh;
  logic [19:0] dl, dr, pl, ram_wr_data, ram_rd_data, q, dt;
  logic [39:0] cell_out;
  logic [19:0] out_l, out_r;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 clock = ~clock;
  cluster_neighbour i_nb (.clock(clock), .reset_n(reset_n), .tick_req(tick_req),
    .tick_line(tline), .pat_left(pl), .pat_right(20'h0_0000), .row_clock(row_clock),
    .direct_in_left(dl), .direct_in_right(dr));
  logic_cluster i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .row_clock(row_clock), .clk_enable(clk_enable), .cluster_clear(cluster_clear),
    .device_wide_clear_n(device_wide_clear_n), .sync_clear(sync_clear), .sync_load(sync_load),
    .cell_input_a(a), .cell_input_b(b), .cell_input_c(c), .cell_input_d(d),
    .cell_input_e_low(el), .cell_input_e_high(eh), .cell_input_f_low(fl),
    .cell_input_f_high(fh), .direct_in_left(dl), .direct_in_right(dr),
    .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr), .ram_wr_data(ram_wr_data),
    .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data), .cell_out(cell_out),
    .direct_out_left(out_l), .direct_out_right(out_r));
  task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [8:0] ad, input logic [31:0] dv);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= dv;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] ad, output logic [31:0] dv);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 dv = reg_rdata;
  endtask
  // Row edge needs three cycles to land, then one more to reach the output
  task automatic tick();
    @(posedge clock);
    tick_req <= 1'b1;
    @(posedge clock);
    tick_req <= 1'b0;
    repeat (14) @(posedge clock);
    #1;
  endtask
  task automatic ram_acc(input logic [5:0] ad, input logic [19:0] dv);
    @(posedge clock);
    ram_wr_en <= 1'b1;
    ram_wr_addr <= ad;
    ram_wr_data <= dv;
    @(posedge clock);
    ram_wr_en <= 1'b0;
    ram_rd_addr <= ad;
    @(posedge clock);
    #1 q = ram_rd_data;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    clock = 0; reset_n = 0; reg_write = 0; reg_read = 0; reg_addr = 0; reg_wdata = 0;
    device_wide_clear_n = 1; sync_clear = 0; sync_load = 0; clk_enable = 0; cluster_clear = 0;
    ram_wr_en = 0; ram_wr_addr = 0; ram_wr_data = 0; ram_rd_addr = 0; tick_req = 0; pl = 0;
    tline = 0;
    {a, b, c, d, el, eh, fl, fh} = '0;
    seed = $urandom(32'h586E8B70);
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    #1 check("out after reset", cell_out, 40'h00_0000_0000);
    wr(`ADDR_GLOBAL, 32'h0000_3038);
    rd(`ADDR_GLOBAL, rv);
    check("global", rv, 40'h3038);
    wr(9'h010, 32'h0001_1000);
    rd(9'h010, rv);
    check("control", rv, 40'h0001_1000);
    rd(9'h14C, rv);
    check("unmapped", rv, 40'h0);
    $display("test registers done");
    wr(9'h000, 32'hAAAA_AAAA);
    wr(9'h004, 32'hAAAA_AAAA);
    wr(9'h010, 32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      {a, b, c, d, el, eh, fl, fh} <= 80'({$urandom, $urandom, $urandom});
      repeat (3) @(posedge clock);
      #1 check("bypass out", cell_out[0], a[0]);
      // No register has ticked yet, so only the bypassed bit can be set
      check("left link", out_l, {19'h0_0000, a[0]});
      check("right link", out_r, 20'h0_0000);
    end
    $display("test bypass done");
    wr(9'h020, 32'hAAAA_AAAA);
    wr(9'h024, 32'hAAAA_AAAA);
    wr(9'h030, 32'h0000_0018);
    for (int i = 0; i < 4; i++) begin
      dt = $urandom;
      @(posedge clock);
      pl <= dt;
      a <= {8'h00, ~dt[2], 1'b0};
      repeat (4) @(posedge clock);
      #1 check("direct in", cell_out[4], dt[2]);
    end
    $display("test direct done");
    // Cell 0: lookup gives a, reg0 on clock 0, honours sync controls, clear 0
    wr(9'h010, 32'h0010_1000);
    a <= 10'h001; clk_enable <= 3'h1;
    tick();
    check("reg load", cell_out[0], 1'b1);
    a <= 10'h000; clk_enable <= 3'h0;
    tick();
    check("reg hold", cell_out[0], 1'b1);
    clk_enable <= 3'h1; sync_clear <= 1'b1; sync_load <= 1'b1; c <= 10'h001;
    tick();
    check("sync clear wins", cell_out[0], 1'b0);
    sync_clear <= 1'b0;
    tick();
    check("sync load", cell_out[0], 1'b1);
    sync_load <= 1'b0; cluster_clear <= 2'h1;
    repeat (6) @(posedge clock);
    #1 check("cluster clear", cell_out[0], 1'b0);
    cluster_clear <= 2'h0; a <= 10'h001;
    tick();
    device_wide_clear_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1 check("device clear", cell_out[0], 1'b0);
    device_wide_clear_n <= 1'b1;
    // Preset register on the second cluster clear
    wr(9'h010, 32'h0021_1000);
    a <= 10'h000;
    tick();
    check("preset data", cell_out[0], 1'b0);
    cluster_clear <= 2'h2;
    repeat (6) @(posedge clock);
    #1 check("preset clear", cell_out[0], 1'b1);
    cluster_clear <= 2'h0;
    $display("test cell registers done");
    for (int i = 0; i < 8; i++) begin
      dt = $urandom;
      ram_acc({1'b0, 5'($urandom)}, dt);
      check("ram 32x20", q, dt);
    end
    // Width code 0..2 selects 8, 9 or 10 stored bits
    for (int w = 0; w < 3; w++) begin
      wr(`ADDR_GLOBAL, 32'h0000_4038 | (32'(w) << 15));
      dt = $urandom;
      ram_acc(6'h05, dt);
      check("ram 64 deep", q[9:0], dt[9:0] & ((10'h100 << w) - 10'h001));
    end
    $display("test ram done");
    // Reg2 packed from e_high, reg0 from half0, reg3 from the empty half1
    wr(9'h010, 32'h0000_0400);
    a <= 10'h000;
    c <= 10'h001;
    eh <= 10'h001;
    clk_enable <= 3'h1;
    tick();
    check("packed reg", cell_out[3:0], 4'h4);
    // Half0 looks at c, which feedback replaces by reg0
    wr(9'h000, 32'hF0F0_F0F0);
    wr(9'h004, 32'hF0F0_F0F0);
    wr(9'h010, 32'h0000_1024);
    sync_load <= 1'b1;
    tick();
    sync_load <= 1'b0;
    c <= 10'h000;
    repeat (3) @(posedge clock);
    #1 check("feedback", cell_out[1], 1'b1);
    // Half1 follows e_high; extended mode lets f_low pick the half
    wr(9'h008, 32'hFFFF_0000);
    wr(9'h00C, 32'hFFFF_0000);
    for (int m = 0; m < 2; m++) begin
      wr(9'h010, 32'h0000_0050 | 32'(m));
      for (int i = 0; i < 4; i++) begin
        @(posedge clock);
        {a, b, c, d, el, eh, fl, fh} <= 80'({$urandom, $urandom, $urandom});
        repeat (3) @(posedge clock);
        #1 check("half0 out", cell_out[0], (m == 1 && fl[0]) ? eh[0] : c[0]);
        check("half1 out", cell_out[2], (m == 1 && !fl[0]) ? c[0] : eh[0]);
      end
    end
    // Clock 1 from source1 on row line 3, inverted: ticks when the line falls
    wr(`ADDR_GLOBAL, 32'h0000_0318);
    wr(9'h010, 32'h1000_0000);
    c <= 10'h000;
    tline <= 3'h3;
    clk_enable <= 3'h2;
    tick();
    check("inverted clock", cell_out[0], 1'b0);
    $display("test cell modes done");
    finish_test();
  end
endmodule
